/* File: core/beat_delay.sv */
// delay line that aligns a read beat with its data after cas latency
`timescale 1ns/100ps
module beat_delay
  import trace_pkg::*;
#(
  parameter int MAX_DEPTH = CAS_LATENCY_MAX
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // beat entering and its flag
  input wire logic beat_in,
  input wire logic flag_in,
  input wire logic [1:0] depth,
  // aligned beat and flag
  output logic beat_out,
  output logic flag_out
);
  initial begin
    // the two-bit depth reaches tap two, so exactly three stages are needed
    if (MAX_DEPTH != 3) begin
      $error("beat_delay depth out of range");
    end
  end

  logic [MAX_DEPTH:0] beat_line;
  logic [MAX_DEPTH:0] flag_line;

  // shift register with tap chosen by programmed latency
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      beat_line <= '0;
      flag_line <= '0;
    end else begin
      beat_line <= {beat_line[MAX_DEPTH-1:0], beat_in};
      flag_line <= {flag_line[MAX_DEPTH-1:0], flag_in};
    end
  end

  // tap select: stage n holds the beat n+1 clocks late, depth zero bypasses
  always_comb begin
    beat_out = beat_line[depth - 2'h1];
    flag_out = flag_line[depth - 2'h1];
    if (depth == 2'd0) begin
      beat_out = beat_in;
      flag_out = flag_in;
    end
  end
endmodule : beat_delay

/* File: core/code_fetch_trace.sv */
// three-pin code-fetch trace port with write-buffer contributor alternate use
// Notes on behaviour
// [R01] pins run code-fetch trace mode while write-buffer test select is zero
// [R02] reset leaves trace mode selected with no software action
// [R03] sdram read flag low for cpu demand code fetch or its prefetch
// [R04] sdram read flag high for any non code read from any initiator
// [R05] sdram write flag high when dma or pci contributed any data
// [R06] sdram write flag low when only the cpu contributed data
// [R07] strobe low while data invalid, high when data latchable next edge
// [R08] strobe tracks data for every programmed cas latency
// [R09] capture side latches flags, address and data where strobe sampled high; trace_capture samples flags every edge and holds no address or data
// [R10] no strobe during read phase of ecc read-modify-write
// [R11] rom/bus flag valid at rising edge of rom or bus read strobe
// [R12] capture side samples rom/bus flag only while a read strobe asserted; trace_capture samples it every edge and got_rom marks strobe edges
// [R13] rom/bus flag low only for cpu code fetch from rom or bus memory
// [R14] only the cpu may start rom accesses, so rom cycles are cpu cycles
// [R15] pci master cycles are never forwarded to the general bus
// [R16] dma address enable high during dma and echoed cycles
// [R17] bus devices suppress decoding while dma address enable high
// [R18] rom cycles put unmultiplexed address on the bus address lines
// [R19] strobe leaves on the pin of write-buffer master bit 1
// [R20] capture side rebuilds 28-bit address from bank and row/column lines; trace_capture has no address inputs
// [R21] rom/bus flag, strobe, sdram flag share master bits 0, 1, 2
// [R22] test select one drives contributor codes onto the three pins
// [R23] strobe high one clock per beat; flags change only on clock edges
`timescale 1ns/100ps
module code_fetch_trace
  import trace_pkg::*;
#(
  parameter int ADDR_WIDTH = 26
) (
  // memory feedback clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // mode select and timing configuration
  input wire logic control_write,
  input wire logic [31:0] control_wdata,
  input wire logic [1:0] cas_latency,
  input wire logic ecc_enable,
  // sdram controller cycle information
  input wire cycle_kind_e sdram_cycle,
  input wire logic sdram_beat,
  input wire logic sdram_code_fetch,
  input wire logic sdram_cpu_prefetch,
  input wire logic [2:0] wbuf_contributors,
  input wire logic [2:0] read_master,
  // rom and general bus cycle information
  input wire logic rom_cycle,
  input wire logic bus_cycle,
  input wire logic cpu_code_fetch,
  input wire logic bus_dma_cycle,
  input wire logic bus_echo_cycle,
  input wire logic pci_request,
  input wire logic cpu_request,
  input wire logic [ADDR_WIDTH-1:0] cpu_address,
  // trace pins
  output logic wbuf_master_bit0,
  output logic wbuf_master_bit1,
  output logic wbuf_master_bit2,
  // rom and bus outputs
  output logic rom_read_strobe,
  output logic bus_memory_read_strobe,
  output logic bus_dma_address_enable,
  output logic bus_forward,
  output logic [ADDR_WIDTH-1:0] bus_address_lines,
  // mode status
  output logic wbuf_test_select
);
  initial begin
    if (ADDR_WIDTH < 1 || ADDR_WIDTH > 26) begin
      $error("code_fetch_trace address width out of range");
    end
  end

  logic sdram_code_fetch_flag;
  logic sdram_data_valid_strobe;
  logic rom_bus_code_fetch_flag;
  logic [2:0] wbuf_code;
  logic next_sdram_flag;
  logic read_beat;
  logic read_flag;
  logic aligned_beat;
  logic aligned_flag;
  logic write_beat;
  logic read_active;

  // mode select bit, trace mode after reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wbuf_test_select <= WBUF_TEST_SELECT_RESET; // [R02]
    end else if (control_write) begin
      wbuf_test_select <= control_wdata[WBUF_TEST_SELECT_POS]; // [R01]
    end
  end

  // classify the sdram cycle for flag and strobe
  always_comb begin
    read_beat = sdram_beat && (sdram_cycle == CYC_READ);
    // ecc read-modify-write read phase gives no beat
    if (sdram_cycle == CYC_RMW_READ && ecc_enable) begin
      read_beat = 1'b0; // [R10]
    end
    read_flag = !(sdram_code_fetch || sdram_cpu_prefetch); // [R03] [R04]
    write_beat = sdram_beat && (sdram_cycle == CYC_WRITE);
  end

  // read data appears cas latency clocks after the command beat
  beat_delay #(
    .MAX_DEPTH(CAS_LATENCY_MAX)
  ) u_read_align (
    .clock(clock),
    .rst_n(rst_n),
    .beat_in(read_beat),
    .flag_in(read_flag),
    .depth(cas_latency),
    .beat_out(aligned_beat),
    .flag_out(aligned_flag)
  ); // [R08]

  // write flag from contributors: high if dma or pci wrote any byte
  always_comb begin
    next_sdram_flag = sdram_code_fetch_flag;
    if (write_beat) begin
      next_sdram_flag = wbuf_contributors[CODE_DMA_POS]
        || wbuf_contributors[CODE_PCI_POS]; // [R05] [R06]
    end else if (aligned_beat) begin
      next_sdram_flag = aligned_flag; // [R03] [R04]
    end
  end

  // strobe and sdram flag registered, one clock per beat
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sdram_data_valid_strobe <= 1'b0;
      sdram_code_fetch_flag <= 1'b1;
    end else begin
      sdram_data_valid_strobe <= write_beat || aligned_beat; // [R07] [R23]
      sdram_code_fetch_flag <= next_sdram_flag; // [R23]
    end
  end

  // rom cycles are cpu only; pci never reaches the general bus
  always_comb begin
    bus_forward = bus_cycle && cpu_request && !pci_request; // [R15]
    read_active = (rom_cycle && cpu_request) || bus_forward; // [R14]
  end

  // rom/bus read strobes and flag, flag set on the same edge the strobe rises
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rom_read_strobe <= 1'b0;
      bus_memory_read_strobe <= 1'b0;
      rom_bus_code_fetch_flag <= 1'b1;
    end else begin
      rom_read_strobe <= rom_cycle && cpu_request; // [R14]
      bus_memory_read_strobe <= bus_forward && !bus_dma_cycle;
      if (read_active) begin
        rom_bus_code_fetch_flag <= !cpu_code_fetch; // [R11] [R13]
      end
    end
  end

  // bus address and dma address enable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_address_lines <= '0;
      bus_dma_address_enable <= 1'b0;
    end else begin
      bus_dma_address_enable <= bus_dma_cycle || bus_echo_cycle; // [R16]
      if (rom_cycle || bus_forward) begin
        bus_address_lines <= cpu_address; // [R18]
      end
    end
  end

  // contributor code: write contributors for write and rmw read, read master for reads, zero when idle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wbuf_code <= 3'h0;
    end else if (sdram_cycle == CYC_WRITE || sdram_cycle == CYC_RMW_READ) begin
      wbuf_code <= wbuf_contributors; // [R22]
    end else if (sdram_cycle == CYC_READ) begin
      wbuf_code <= read_master; // [R22]
    end else begin
      wbuf_code <= 3'h0;
    end
  end

  // pin multiplex between trace and contributor codes
  always_comb begin
    if (wbuf_test_select) begin
      wbuf_master_bit0 = wbuf_code[CODE_DMA_POS]; // [R22]
      wbuf_master_bit1 = wbuf_code[CODE_PCI_POS];
      wbuf_master_bit2 = wbuf_code[CODE_CPU_POS];
    end else begin
      wbuf_master_bit0 = rom_bus_code_fetch_flag; // [R01] [R21]
      wbuf_master_bit1 = sdram_data_valid_strobe; // [R19]
      wbuf_master_bit2 = sdram_code_fetch_flag; // [R21]
    end
  end

  // checks on the trace behaviour
  AST_DEFAULT_MODE: assert property (@(posedge clock) // [R02]
    !rst_n |=> !wbuf_test_select)
    else $error("trace mode not selected after reset");
  AST_STROBE_PIN: assert property (@(posedge clock) disable iff (!rst_n) // [R19]
    !wbuf_test_select |-> wbuf_master_bit1 == sdram_data_valid_strobe)
    else $error("strobe not on master bit 1");
  AST_WRITE_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // [R05]
    write_beat && (wbuf_contributors[0] || wbuf_contributors[1])
    |=> sdram_code_fetch_flag && sdram_data_valid_strobe)
    else $error("dma or pci write not flagged high");
  AST_CPU_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // [R06]
    write_beat && wbuf_contributors == 3'h4 |=> !sdram_code_fetch_flag)
    else $error("cpu only write not flagged low");
  AST_READ_LATENCY: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
    read_beat && cas_latency == 2'd2 && $stable(cas_latency) ##1 $stable(cas_latency)
    |=> ##1 sdram_data_valid_strobe)
    else $error("read strobe not at cas latency");
  AST_RMW_NO_STROBE: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
    sdram_cycle == CYC_RMW_READ && ecc_enable |-> !read_beat)
    else $error("strobe during ecc read phase");
  AST_STROBE_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // [R07]
    !write_beat && !aligned_beat |=> !sdram_data_valid_strobe)
    else $error("strobe high without data");
  AST_ROM_FLAG: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    read_active && cpu_code_fetch |=> !rom_bus_code_fetch_flag)
    else $error("rom code fetch not flagged low");
  AST_NO_PCI_BUS: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
    pci_request |-> !bus_forward)
    else $error("pci cycle forwarded to bus");
  AST_DMA_AEN: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
    bus_dma_cycle || bus_echo_cycle |=> bus_dma_address_enable)
    else $error("address enable missing");
  AST_ALT_MODE: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
    wbuf_test_select |-> {wbuf_master_bit2, wbuf_master_bit1, wbuf_master_bit0} == wbuf_code)
    else $error("contributor code not on pins");

  // previous read strobe level, to find its rising edge
  logic read_strobe_prev;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_strobe_prev <= 1'b0;
    end else begin
      read_strobe_prev <= rom_read_strobe || bus_memory_read_strobe;
    end
  end

  // read strobe for latencies zero, one and three: one clock more than the latency
  AST_READ_LAT0: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
    read_beat && cas_latency == 2'h0 |=> sdram_data_valid_strobe)
    else $error("read strobe not at latency zero");
  AST_READ_LAT1: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
    read_beat && cas_latency == 2'h1 ##1 cas_latency == 2'h1 |=> sdram_data_valid_strobe)
    else $error("read strobe not at latency one");
  AST_READ_LAT3: assert property (@(posedge clock) disable iff (!rst_n) // [R08]
    read_beat && cas_latency == 2'h3 ##1 cas_latency == 2'h3 ##1 cas_latency == 2'h3
    ##1 cas_latency == 2'h3 |=> sdram_data_valid_strobe)
    else $error("read strobe not at latency three");
  // any read beat shows its strobe within one clock more than the longest latency
  AST_READ_BOUND: assert property (@(posedge clock) disable iff (!rst_n) // [R07]
    read_beat |-> ##[1:4] sdram_data_valid_strobe)
    else $error("read strobe missing");

  // read flag from the code fetch inputs, seen at latency zero
  AST_READ_CODE_LOW: assert property (@(posedge clock) disable iff (!rst_n) // [R03]
    read_beat && cas_latency == 2'h0 && (sdram_code_fetch || sdram_cpu_prefetch)
    |=> !sdram_code_fetch_flag)
    else $error("code read not flagged low");
  AST_READ_DATA_HIGH: assert property (@(posedge clock) disable iff (!rst_n) // [R04]
    read_beat && cas_latency == 2'h0 && !sdram_code_fetch && !sdram_cpu_prefetch
    |=> sdram_code_fetch_flag)
    else $error("data read not flagged high");
  // sdram flag moves only with a beat
  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [R23]
    !write_beat && !aligned_beat |=> $stable(sdram_code_fetch_flag))
    else $error("sdram flag changed without beat");

  // rom/bus flag polarity and hold
  AST_ROM_DATA: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
    read_active && !cpu_code_fetch |=> rom_bus_code_fetch_flag)
    else $error("rom data read not flagged high");
  AST_ROM_FLAG_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
    !read_active |=> $stable(rom_bus_code_fetch_flag))
    else $error("rom flag changed outside a read");
  // flag already valid where the read strobe rises
  AST_FLAG_AT_RISE: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
    (rom_read_strobe || bus_memory_read_strobe) && !read_strobe_prev
    |-> rom_bus_code_fetch_flag == !$past(cpu_code_fetch))
    else $error("rom flag not valid at strobe rise");

  // rom strobe only for cpu cycles, bus strobe never for pci
  AST_ROM_CPU_ONLY: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
    rom_read_strobe |-> $past(cpu_request))
    else $error("rom strobe without cpu request");
  AST_BUS_NO_PCI: assert property (@(posedge clock) disable iff (!rst_n) // [R15]
    bus_memory_read_strobe |-> !$past(pci_request))
    else $error("bus strobe for pci cycle");

  // address enable low outside dma and echo cycles
  AST_AEN_LOW: assert property (@(posedge clock) disable iff (!rst_n) // [R16]
    !bus_dma_cycle && !bus_echo_cycle |=> !bus_dma_address_enable)
    else $error("address enable without dma");
  // rom address reaches the bus lines unmultiplexed
  AST_ROM_ADDRESS: assert property (@(posedge clock) disable iff (!rst_n) // [R18]
    rom_cycle |=> bus_address_lines == $past(cpu_address))
    else $error("rom address not on bus lines");

  // trace mode pins carry both flags
  AST_TRACE_PINS: assert property (@(posedge clock) disable iff (!rst_n) // [R21]
    !wbuf_test_select |-> wbuf_master_bit0 == rom_bus_code_fetch_flag
    && wbuf_master_bit2 == sdram_code_fetch_flag)
    else $error("trace flags not on pins");
  // select follows a control write and holds otherwise
  AST_SELECT_WRITE: assert property (@(posedge clock) disable iff (!rst_n) // [R01]
    control_write |=> wbuf_test_select == $past(control_wdata[WBUF_TEST_SELECT_POS]))
    else $error("select bit not written");
  AST_SELECT_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [R01]
    !control_write |=> $stable(wbuf_test_select))
    else $error("select bit changed without write");

  // contributor code follows the cycle kind
  AST_CODE_IDLE: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
    sdram_cycle == CYC_IDLE |=> wbuf_code == 3'h0)
    else $error("contributor code not cleared when idle");
  AST_CODE_READ: assert property (@(posedge clock) disable iff (!rst_n) // [R22]
    sdram_cycle == CYC_READ |=> wbuf_code == $past(read_master))
    else $error("read master not on contributor code");

  // main scenarios
  COV_WRITE: cover property (@(posedge clock) disable iff (!rst_n) write_beat);
  COV_READ: cover property (@(posedge clock) disable iff (!rst_n) aligned_beat);
  COV_ROM: cover property (@(posedge clock) disable iff (!rst_n) rom_read_strobe);
  COV_ALT: cover property (@(posedge clock) disable iff (!rst_n) wbuf_test_select);
  COV_RMW: cover property (@(posedge clock) disable iff (!rst_n)
    sdram_cycle == CYC_RMW_READ && ecc_enable && sdram_beat);
endmodule : code_fetch_trace

/* File: core/trace_pkg.sv */
// shared constants for the code-fetch trace port
package trace_pkg;
  // control register location and select bit
  localparam logic [11:0] SDRAM_CONTROL_OFFSET = 12'h010;
  localparam int WBUF_TEST_SELECT_POS = 4;
  localparam logic WBUF_TEST_SELECT_RESET = 1'h0;
  // default cas latency and its legal range in memory clocks
  localparam int CAS_LATENCY_DEFAULT = 2;
  localparam int CAS_LATENCY_MAX = 3;
  // contributor code bit positions on the shared pins
  localparam int CODE_DMA_POS = 0;
  localparam int CODE_PCI_POS = 1;
  localparam int CODE_CPU_POS = 2;
  // cycle kinds presented by the sdram controller
  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_READ = 2'b01,
    CYC_WRITE = 2'b10,
    CYC_RMW_READ = 2'b11
  } cycle_kind_e;
endpackage : trace_pkg

/* File: testbench/code_fetch_trace_tb_top.sv */
// self-checking bench for the code-fetch trace port
`timescale 1ns/100ps
module code_fetch_trace_tb_top;
  import trace_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, control_write = 1'b0, ecc_enable = 1'b0;
  logic [31:0] control_wdata = 32'h0, lfsr = 32'h00010d49;
  logic [1:0] cas_latency = 2'h0;
  cycle_kind_e sdram_cycle = CYC_IDLE;
  logic sdram_beat = 1'b0, sdram_code_fetch = 1'b0, sdram_cpu_prefetch = 1'b0;
  logic [2:0] wbuf_contributors = 3'h5, read_master = 3'h5;
  logic rom_cycle = 1'b0, bus_cycle = 1'b0, cpu_code_fetch = 1'b0, bus_dma_cycle = 1'b0;
  logic bus_echo_cycle = 1'b0, pci_request = 1'b0, cpu_request = 1'b0;
  logic [25:0] cpu_address = 26'h0, bus_address_lines;
  logic wbuf_master_bit0, wbuf_master_bit1, wbuf_master_bit2, rom_read_strobe;
  logic bus_memory_read_strobe, bus_dma_address_enable, bus_forward, wbuf_test_select;
  logic got_beat, beat_flag, got_rom, rom_seen;
  logic exp_q[$];
  int n_fail = 0, tests_run = 0;
  // device and capture model
  code_fetch_trace dut (.*);
  trace_capture cap (.clock(clock), .strobe(wbuf_master_bit1), .sdram_flag(wbuf_master_bit2),
    .rom_flag(wbuf_master_bit0), .rom_rd(rom_read_strobe), .bus_rd(bus_memory_read_strobe),
    .got_beat(got_beat), .beat_flag(beat_flag), .got_rom(got_rom), .rom_seen(rom_seen));
  // 125 MHz memory clock
  initial forever #4 clock = ~clock;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test
  // one sdram beat, noting the flag expected when its strobe shows up
  task automatic beat(input cycle_kind_e k, input logic [2:0] who, input logic cf, input logic pf);
    @(posedge clock);
    sdram_cycle <= k;
    sdram_beat <= 1'b1;
    wbuf_contributors <= who;
    read_master <= who;
    sdram_code_fetch <= cf;
    sdram_cpu_prefetch <= pf;
    if (k == CYC_WRITE) exp_q.push_back(who[1:0] != 2'h0);
    else if (k == CYC_READ) exp_q.push_back(!(cf | pf));
  endtask : beat
  // go idle and wait for every noted beat to be captured
  task automatic drain();
    int i;
    @(posedge clock);
    sdram_beat <= 1'b0;
    sdram_cycle <= CYC_IDLE;
    for (i = 0; i < 24 && exp_q.size() > 0; i++) @(posedge clock);
    repeat (6) @(posedge clock);
    chk("pending beats", exp_q.size(), 0);
    if (i == 24) stop_test();
  endtask : drain
  // one rom or bus memory read by the cpu
  task automatic romcyc(input logic on_rom, input logic cf);
    int i;
    @(posedge clock);
    rom_cycle <= on_rom;
    bus_cycle <= !on_rom;
    cpu_code_fetch <= cf;
    cpu_request <= 1'b1;
    cpu_address <= 26'(rnd());
    for (i = 0; i < 8 && got_rom !== 1'b1; i++) @(posedge clock);
    chk("rom read strobe", got_rom, 1);
    chk("rom flag", rom_seen, !cf);
    if (on_rom) chk("rom address", bus_address_lines, cpu_address);
    if (i == 8) stop_test();
    rom_cycle <= 1'b0;
    bus_cycle <= 1'b0;
    cpu_request <= 1'b0;
    repeat (3) @(posedge clock);
  endtask : romcyc
  // every captured strobe must match the oldest noted beat
  always @(posedge clock) begin
    if (got_beat === 1'b1) begin
      if (exp_q.size() == 0) chk("stray strobe", 1, 0);
      else chk("sdram flag", beat_flag, exp_q.pop_front());
    end
  end
  initial begin
    logic [31:0] r;
    int lat;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk("select after reset", wbuf_test_select, 0);
    chk("strobe after reset", wbuf_master_bit1, 0);
    beat(CYC_WRITE, 3'h4, 1'b0, 1'b0);
    beat(CYC_WRITE, 3'h7, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) beat(CYC_WRITE, 3'(rnd()) | 3'h4, 1'b0, 1'b0);
    drain();
    for (lat = 0; lat < 4; lat++) begin
      cas_latency <= 2'(lat);
      repeat (2) @(posedge clock);
      for (int i = 0; i < 6; i++) begin
        r = rnd();
        beat(CYC_READ, 3'h1 << r[3:2], r[0], r[1]);
      end
      drain();
    end
    ecc_enable <= 1'b1;
    beat(CYC_RMW_READ, 3'h4, 1'b0, 1'b0);
    beat(CYC_RMW_READ, 3'h4, 1'b0, 1'b0);
    beat(CYC_READ, 3'h4, 1'b1, 1'b0);
    drain();
    ecc_enable <= 1'b0;
    romcyc(1'b1, 1'b1);
    romcyc(1'b1, 1'b0);
    romcyc(1'b0, 1'b1);
    romcyc(1'b0, 1'b0);
    bus_dma_cycle <= 1'b1;
    repeat (2) @(posedge clock);
    chk("dma address enable", bus_dma_address_enable, 1);
    bus_dma_cycle <= 1'b0;
    bus_echo_cycle <= 1'b1;
    repeat (2) @(posedge clock);
    chk("echo address enable", bus_dma_address_enable, 1);
    bus_echo_cycle <= 1'b0;
    bus_cycle <= 1'b1;
    pci_request <= 1'b1;
    cpu_request <= 1'b1;
    repeat (2) @(posedge clock);
    chk("address enable idle", bus_dma_address_enable, 0);
    chk("pci forward", bus_forward, 0);
    bus_cycle <= 1'b0;
    pci_request <= 1'b0;
    cpu_request <= 1'b0;
    wbuf_contributors <= 3'h5;
    read_master <= 3'h5;
    control_write <= 1'b1;
    control_wdata <= 32'h10;
    @(posedge clock);
    control_write <= 1'b0;
    repeat (2) @(posedge clock);
    chk("select set", wbuf_test_select, 1);
    sdram_cycle <= CYC_WRITE;
    repeat (2) @(posedge clock);
    chk("alt pins", {wbuf_master_bit2, wbuf_master_bit1, wbuf_master_bit0}, 3'h5);
    sdram_cycle <= CYC_IDLE;
    repeat (2) @(posedge clock);
    control_write <= 1'b1;
    control_wdata <= 32'h0;
    @(posedge clock);
    control_write <= 1'b0;
    repeat (2) @(posedge clock);
    chk("select clear", wbuf_test_select, 0);
    beat(CYC_WRITE, 3'h2, 1'b0, 1'b0);
    drain();
    stop_test();
  end
endmodule : code_fetch_trace_tb_top

/* File: testbench/trace_capture.sv */
// capture model that latches trace pins the way an analyzer would
`timescale 1ns/100ps
module trace_capture (
  // memory feedback clock
  input wire logic clock,
  // trace pins and read strobes
  input wire logic strobe,
  input wire logic sdram_flag,
  input wire logic rom_flag,
  input wire logic rom_rd,
  input wire logic bus_rd,
  // captured values
  output logic got_beat,
  output logic beat_flag,
  output logic got_rom,
  output logic rom_seen
);
  // take strobe and flag at every edge; got_beat marks edges where the strobe was high
  always_ff @(posedge clock) begin
    got_beat <= strobe;
    beat_flag <= sdram_flag;
  end
  // take rom/bus flag at every edge; got_rom marks edges where a read strobe was high
  always_ff @(posedge clock) begin
    got_rom <= rom_rd | bus_rd;
    rom_seen <= rom_flag;
  end
endmodule : trace_capture
